// file: rtcdm_calendar.sv
`timescale 1ns/1ps
// Summary of operation
// - day of month kept as bcd 01..31 in bits 5..0
// - february gets day 29 when year divisible by four, 00 included
// - weekday is a three bit value 0..6, meaning left to software
// - month bit 7 is century: 0 means 20xx, 1 means 19xx
// - century bit flips when the year wraps from 99 to 00
// - month kept as bcd 01..12 in bits 4..0
// - year kept as eight bit bcd 00..99
// - flag sets when all enabled match fields first agree with time
// - flag stays set until software clears it
// - after clearing, flag sets only on a new arrival at the match
// - match registers with disable bit high are ignored
// - bit 7 of each match register is an active low enable
// - minute match holds bcd 00..59 in bits 6..0
// - hour match holds bcd 00..23 in its low bits
// - day match holds bcd 01..31 in its low bits
// - weekday match holds 0..6 in its low bits
// - writing 0 clears the flag, writing 1 leaves it alone
// - interrupt pin follows the flag only while irq enable is 1
module rtcdm_calendar
  import rtcdm_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // register port from the serial interface
  input  wire logic [3:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata_q,
  // time of day from the hour and minute counters
  input  wire logic [6:0] cur_minute,
  input  wire logic [5:0] cur_hour,
  input  wire logic       hour_wrap,
  // interrupt pin, open drain
  output logic            irq_out_q,
  output logic            irq_oe_q
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rtcdm_date_t  date_q;
  rtcdm_date_t  date_nxt;
  rtcdm_match_t mreg_q;
  logic         flag_q;
  logic         irq_en_q;
  logic         hit;
  logic         wr_day;
  logic         wr_wday;
  logic         wr_month;
  logic         wr_year;
  logic         wr_ctrl2;
  logic         date_wr;

  assign wr_day   = reg_wr && (reg_addr == OFS_DAY);
  assign wr_wday  = reg_wr && (reg_addr == OFS_WDAY);
  assign wr_month = reg_wr && (reg_addr == OFS_MONTH);
  assign wr_year  = reg_wr && (reg_addr == OFS_YEAR);
  assign wr_ctrl2 = reg_wr && (reg_addr == OFS_CTRL2);
  assign date_wr  = wr_day || wr_wday || wr_month || wr_year;

  // ----------------------------------------------------------------
  // calendar advance
  // ----------------------------------------------------------------
  rtcdm_date_next u_next (
    .cur (date_q),
    .nxt (date_nxt)
  );

  // a software write in the same cycle as the hour wrap wins for the
  // whole date, so a half-updated date can never be seen
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      date_q <= '{century: 1'b0, month: RST_MONTH, day: RST_DAY,
                  wday: 3'd0, year: RST_YEAR};
    end else if (date_wr) begin
      if (wr_day) date_q.day <= reg_wdata[5:0];
      if (wr_wday) date_q.wday <= reg_wdata[2:0];
      if (wr_month) begin
        date_q.century <= reg_wdata[CENT_BIT];
        date_q.month   <= reg_wdata[4:0];
      end
      if (wr_year) date_q.year <= reg_wdata;
    end else if (hour_wrap) begin
      date_q <= date_nxt;
    end
  end

  // ----------------------------------------------------------------
  // match registers
  // ----------------------------------------------------------------
  // only the documented value bits are stored; unused bits read zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mreg_q <= '{minute: RST_MATCH, hour: RST_MATCH, day: RST_MATCH,
                  wday: RST_MATCH};
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_MIN_M:  mreg_q.minute <= reg_wdata;
        OFS_HOUR_M: mreg_q.hour <= {reg_wdata[7], 1'b0, reg_wdata[5:0]};
        OFS_DAY_M:  mreg_q.day <= {reg_wdata[7], 1'b0, reg_wdata[5:0]};
        OFS_WDAY_M: mreg_q.wday <= {reg_wdata[7], 4'h0, reg_wdata[2:0]};
        default: ;
      endcase
    end
  end

  rtcdm_match u_match (
    .clock      (clock),
    .rstn       (rstn),
    .mreg       (mreg_q),
    .cur_minute (cur_minute),
    .cur_hour   (cur_hour),
    .cur_date   (date_q),
    .hit        (hit)
  );

  // ----------------------------------------------------------------
  // flag and interrupt enable
  // ----------------------------------------------------------------
  // a hit in the cycle of a clearing write wins, so no event is lost
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) flag_q <= 1'b0;
    else if (hit) flag_q <= 1'b1;
    else if (wr_ctrl2 && !reg_wdata[FLAG_BIT]) flag_q <= 1'b0;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) irq_en_q <= 1'b0;
    else if (wr_ctrl2) irq_en_q <= reg_wdata[IRQ_EN_BIT];
  end

  // pin is pulled low while active; the low level itself is constant
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_out_q <= 1'b0;
      irq_oe_q  <= 1'b0;
    end else begin
      irq_out_q <= 1'b0;
      irq_oe_q  <= flag_q && irq_en_q;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // timer bits of the control register belong elsewhere and read zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL2:  reg_rdata_q <= {4'h0, flag_q, 1'b0, irq_en_q, 1'b0};
        OFS_DAY:    reg_rdata_q <= {2'b00, date_q.day};
        OFS_WDAY:   reg_rdata_q <= {5'h00, date_q.wday};
        OFS_MONTH:  reg_rdata_q <= {date_q.century, 2'b00, date_q.month};
        OFS_YEAR:   reg_rdata_q <= date_q.year;
        OFS_MIN_M:  reg_rdata_q <= mreg_q.minute;
        OFS_HOUR_M: reg_rdata_q <= mreg_q.hour;
        OFS_DAY_M:  reg_rdata_q <= mreg_q.day;
        OFS_WDAY_M: reg_rdata_q <= mreg_q.wday;
        default:    reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_wrap_free;
    hour_wrap && !date_wr;
  endsequence

  sequence s_month_end;
    s_wrap_free ##0 (date_q.day == last_day(date_q.month, is_leap(date_q.year)));
  endsequence

  sequence s_year_end;
    s_month_end ##0 (date_q.month == 5'h12);
  endsequence

  chk_day_advance: assert property (
    s_wrap_free ##0 (date_q.day == 6'h09) |=> (date_q.day == 6'h10))
    else $error("day did not carry from 09 to 10");

  chk_feb_leap: assert property (
    s_wrap_free ##0 (date_q.month == 5'h02 && date_q.day == 6'h28 &&
                     is_leap(date_q.year)) |=> (date_q.day == 6'h29))
    else $error("leap february lost its 29th");

  chk_wday_wrap: assert property (
    s_wrap_free ##0 (date_q.wday == 3'd6) |=> (date_q.wday == 3'd0))
    else $error("weekday did not wrap after 6");

  chk_month_end: assert property (
    s_month_end ##0 (date_q.month != 5'h12) |=>
      (date_q.day == RST_DAY) && (date_q.month == $past(date_q.month) + 5'h1 ||
                                   date_q.month == 5'h10))
    else $error("month end did not roll day and month");

  chk_century_flip: assert property (
    s_year_end ##0 (date_q.year == 8'h99) |=>
      (date_q.century != $past(date_q.century)) && (date_q.year == 8'h00))
    else $error("century did not flip on year wrap");

  chk_year_next: assert property (
    s_year_end ##0 (date_q.year == 8'h19) |=>
      (date_q.month == RST_MONTH) && (date_q.year == 8'h20))
    else $error("december did not advance the year");

  chk_flag_stays: assert property (
    flag_q && !(wr_ctrl2 && !reg_wdata[FLAG_BIT]) |=> flag_q)
    else $error("flag dropped without a clearing write");

  chk_flag_clear: assert property (
    flag_q && wr_ctrl2 && reg_wdata[FLAG_BIT] |=> flag_q)
    else $error("writing one disturbed the flag");

  chk_flag_cause: assert property (
    !flag_q ##1 flag_q |-> $past(hit))
    else $error("flag rose without a new match");

  chk_irq_gate: assert property (
    flag_q && irq_en_q |=> irq_oe_q ##0 !irq_out_q)
    else $error("interrupt pin not driven for an enabled flag");

  chk_irq_quiet: assert property (
    !irq_en_q |=> !irq_oe_q)
    else $error("interrupt pin driven while disabled");

  chk_irq_clear: assert property (
    !flag_q |=> !irq_oe_q)
    else $error("interrupt pin driven without a flag");

  // ----------------------------------------------------------------
  // register storage, read back and further calendar and flag checks
  // ----------------------------------------------------------------
  sequence s_all_off;
    mreg_q.minute[DIS_BIT] && mreg_q.hour[DIS_BIT] &&
    mreg_q.day[DIS_BIT] && mreg_q.wday[DIS_BIT];
  endsequence

  chk_day_write: assert property (
    wr_day |=> (date_q.day == $past(reg_wdata[5:0])))
    else $error("day write not stored");

  chk_wday_write: assert property (
    wr_wday |=> (date_q.wday == $past(reg_wdata[2:0])))
    else $error("weekday write not stored");

  chk_cent_write: assert property (
    wr_month |=> (date_q.century == $past(reg_wdata[CENT_BIT])))
    else $error("century write not stored");

  chk_month_write: assert property (
    wr_month |=> (date_q.month == $past(reg_wdata[4:0])))
    else $error("month write not stored");

  chk_year_write: assert property (
    wr_year |=> (date_q.year == $past(reg_wdata)))
    else $error("year write not stored");

  chk_wday_step: assert property (
    s_wrap_free ##0 (date_q.wday < 3'd6) |=>
      (date_q.wday == $past(date_q.wday) + 3'd1))
    else $error("weekday did not advance by one");

  chk_feb_common: assert property (
    s_wrap_free ##0 (date_q.month == 5'h02 && date_q.day == 6'h28 &&
                     !is_leap(date_q.year)) |=>
      (date_q.day == RST_DAY) && (date_q.month == 5'h03))
    else $error("common february did not end on the 28th");

  chk_date_hold: assert property (
    !hour_wrap && !date_wr |=> $stable(date_q))
    else $error("date moved without a wrap or write");

  chk_min_store: assert property (
    reg_wr && (reg_addr == OFS_MIN_M) |=> (mreg_q.minute == $past(reg_wdata)))
    else $error("minute match write not stored");

  chk_hour_store: assert property (
    reg_wr && (reg_addr == OFS_HOUR_M) |=>
      (mreg_q.hour[6] == 1'b0) && (mreg_q.hour[5:0] == $past(reg_wdata[5:0])))
    else $error("hour match write not stored");

  chk_dm_store: assert property (
    reg_wr && (reg_addr == OFS_DAY_M) |=>
      (mreg_q.day[DIS_BIT] == $past(reg_wdata[DIS_BIT])) &&
      (mreg_q.day[5:0] == $past(reg_wdata[5:0])))
    else $error("day match write not stored");

  chk_wdm_store: assert property (
    reg_wr && (reg_addr == OFS_WDAY_M) |=>
      (mreg_q.wday[DIS_BIT] == $past(reg_wdata[DIS_BIT])) &&
      (mreg_q.wday[2:0] == $past(reg_wdata[2:0])))
    else $error("weekday match write not stored");

  chk_flag_set: assert property (
    hit |=> flag_q)
    else $error("match did not set the flag");

  chk_all_off: assert property (
    s_all_off ##1 (s_all_off ##0 !flag_q) |=> !flag_q)
    else $error("flag set with every field disabled");

  chk_flag_read: assert property (
    reg_rd && (reg_addr == OFS_CTRL2) |=> (reg_rdata_q[FLAG_BIT] == $past(flag_q)))
    else $error("flag read back wrong");

  chk_year_read: assert property (
    reg_rd && (reg_addr == OFS_YEAR) |=> (reg_rdata_q == $past(date_q.year)))
    else $error("year read back wrong");

  chk_mon_read: assert property (
    reg_rd && (reg_addr == OFS_MONTH) |=>
      (reg_rdata_q == {$past(date_q.century), 2'b00, $past(date_q.month)}))
    else $error("month read back wrong");

endmodule // rtcdm_calendar

// file: rtcdm_pkg.sv
package rtcdm_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL2   = 4'h1;
  localparam logic [3:0] OFS_DAY     = 4'h5;
  localparam logic [3:0] OFS_WDAY    = 4'h6;
  localparam logic [3:0] OFS_MONTH   = 4'h7;
  localparam logic [3:0] OFS_YEAR    = 4'h8;
  localparam logic [3:0] OFS_MIN_M   = 4'h9;
  localparam logic [3:0] OFS_HOUR_M  = 4'ha;
  localparam logic [3:0] OFS_DAY_M   = 4'hb;
  localparam logic [3:0] OFS_WDAY_M  = 4'hc;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         FLAG_BIT    = 3;
  localparam int         IRQ_EN_BIT  = 1;
  localparam int         CENT_BIT    = 7;
  localparam int         DIS_BIT     = 7;
  localparam logic [5:0] RST_DAY     = 6'h01;
  localparam logic [4:0] RST_MONTH   = 5'h01;
  localparam logic [7:0] RST_YEAR    = 8'h00;
  localparam logic [7:0] RST_MATCH   = 8'h80;

  typedef struct packed {
    logic       century;
    logic [4:0] month;
    logic [5:0] day;
    logic [2:0] wday;
    logic [7:0] year;
  } rtcdm_date_t;

  typedef struct packed {
    logic [7:0] minute;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] wday;
  } rtcdm_match_t;

  // ----------------------------------------------------------------
  // bcd helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else bcd_inc = {v[7:4], v[3:0] + 4'h1};
  endfunction

  // 10*t + u is a multiple of four when u + 2t is
  function automatic logic is_leap(input logic [7:0] y);
    logic [1:0] s;
    s = y[1:0] + {y[4], 1'b0};
    is_leap = (s == 2'b00);
  endfunction

  function automatic logic [5:0] last_day(input logic [4:0] m, input logic leap);
    case (m)
      5'h02:   last_day = leap ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11: last_day = 6'h30;
      default: last_day = 6'h31;
    endcase
  endfunction

endpackage

// file: rtcdm_date_next.sv
`timescale 1ns/1ps
module rtcdm_date_next
  import rtcdm_pkg::*;
(
  // current and next date
  input  rtcdm_date_t cur,
  output rtcdm_date_t nxt
);

  logic [7:0] day_inc;
  logic [7:0] mon_inc;
  logic [7:0] yr_inc;

  assign day_inc = bcd_inc({2'b00, cur.day});
  assign mon_inc = bcd_inc({3'b000, cur.month});
  assign yr_inc  = bcd_inc(cur.year);

  always_comb begin
    nxt      = cur;
    nxt.wday = (cur.wday >= 3'd6) ? 3'd0 : cur.wday + 3'd1;
    if (cur.day >= last_day(cur.month, is_leap(cur.year))) begin
      nxt.day = RST_DAY;
      if (cur.month >= 5'h12) begin
        nxt.month = RST_MONTH;
        if (cur.year == 8'h99) begin
          nxt.year    = RST_YEAR;
          nxt.century = ~cur.century;
        end else begin
          nxt.year = yr_inc;
        end
      end else begin
        nxt.month = mon_inc[4:0];
      end
    end else begin
      nxt.day = day_inc[5:0];
    end
  end

endmodule // rtcdm_date_next

// file: rtcdm_match.sv
`timescale 1ns/1ps
module rtcdm_match
  import rtcdm_pkg::*;
(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rstn,
  // compared values
  input  rtcdm_match_t      mreg,
  input  wire logic [6:0]   cur_minute,
  input  wire logic [5:0]   cur_hour,
  input  rtcdm_date_t       cur_date,
  // result
  output logic              hit
);

  logic eq_min;
  logic eq_hour;
  logic eq_day;
  logic eq_wday;
  logic all_eq;
  logic all_eq_q;

  // a disabled field always counts as equal
  assign eq_min  = mreg.minute[DIS_BIT] || (mreg.minute[6:0] == cur_minute);
  assign eq_hour = mreg.hour[DIS_BIT] || (mreg.hour[6:0] == {1'b0, cur_hour});
  assign eq_day  = mreg.day[DIS_BIT] || (mreg.day[6:0] == {1'b0, cur_date.day});
  assign eq_wday = mreg.wday[DIS_BIT] || (mreg.wday[2:0] == cur_date.wday);
  assign all_eq  = eq_min && eq_hour && eq_day && eq_wday;

  always_ff @(posedge clock or negedge rstn) begin
    // reset state equals the idle level: every field starts disabled, so
    // the comparator already agrees and no false event follows reset
    if (!rstn) all_eq_q <= 1'b1;
    else all_eq_q <= all_eq;
  end

  // only the first cycle of agreement counts, a lasting match does not
  assign hit = all_eq && !all_eq_q;

endmodule // rtcdm_match

// file: rtcdm_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// register bus master model
// ----------------------------------------------------------------
module rtcdm_host_model
  import rtcdm_pkg::*;
(
  // clock
  input  wire logic       clock,
  // register port
  output logic [3:0]      reg_addr,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata_q
);
  initial begin
    reg_addr  = 4'h0;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end
  // idle data shows the inverse of the last byte, so a stale latch cannot pass
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // read data is registered: taken at the strobe edge, held until the next read
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata_q;
  endtask
endmodule // rtcdm_host_model

// file: test_rtcdm_calendar.sv
`timescale 1ns/1ps
module test_rtcdm_calendar
  import rtcdm_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic       clock;
  logic       rstn;
  logic [3:0] reg_addr;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic       reg_rd;
  logic [7:0] reg_rdata_q;
  logic [6:0] cur_minute;
  logic [5:0] cur_hour;
  logic       hour_wrap;
  logic       irq_out_q;
  logic       irq_oe_q;
  logic [7:0] rv;
  int         num_errors;
  int         total_checks;
  int         cycles;

  rtcdm_calendar u_dut (
    .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .cur_minute(cur_minute), .cur_hour(cur_hour), .hour_wrap(hour_wrap),
    .irq_out_q(irq_out_q), .irq_oe_q(irq_oe_q)
  );
  rtcdm_host_model u_host (
    .clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q)
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    u_host.rd(a, rv);
    chk(rv, exp);
  endtask
  task automatic wrap;
    @(posedge clock);
    hour_wrap <= 1'b1;
    @(posedge clock);
    hour_wrap <= 1'b0;
  endtask
  // load a date, let one day pass, read month, day and year back
  task automatic dstep(input logic [7:0] m, d, y, em, ed, ey);
    u_host.wr(OFS_MONTH, m);
    u_host.wr(OFS_DAY, d);
    u_host.wr(OFS_YEAR, y);
    wrap();
    rchk(OFS_MONTH, em);
    rchk(OFS_DAY, ed);
    rchk(OFS_YEAR, ey);
  endtask
  task automatic set_min(input logic [6:0] v);
    @(posedge clock);
    cur_minute <= v;
    repeat (3) @(posedge clock);
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rstn       = 1'b0;
    hour_wrap  = 1'b0;
    cur_minute = 7'h00;
    cur_hour   = 6'h03;
    num_errors = 0;
    total_checks = 0;
    cycles     = 0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    u_host.wr(OFS_CTRL2, 8'h02);
    rchk(4'h3, 8'h00);
    dstep(8'h02, 8'h28, 8'h24, 8'h02, 8'h29, 8'h24);
    dstep(8'h02, 8'h28, 8'h00, 8'h02, 8'h29, 8'h00);
    dstep(8'h02, 8'h28, 8'h23, 8'h03, 8'h01, 8'h23);
    dstep(8'h02, 8'h29, 8'h24, 8'h03, 8'h01, 8'h24);
    dstep(8'h04, 8'h30, 8'h24, 8'h05, 8'h01, 8'h24);
    dstep(8'h07, 8'h30, 8'h24, 8'h07, 8'h31, 8'h24);
    dstep(8'h05, 8'h09, 8'h24, 8'h05, 8'h10, 8'h24);
    dstep(8'h12, 8'h31, 8'h19, 8'h01, 8'h01, 8'h20);
    dstep(8'h07, 8'h31, 8'h24, 8'h08, 8'h01, 8'h24);
    dstep(8'h12, 8'h31, 8'h99, 8'h81, 8'h01, 8'h00);
    dstep(8'h92, 8'h31, 8'h99, 8'h01, 8'h01, 8'h00);
    u_host.wr(OFS_WDAY, 8'h06);
    wrap();
    rchk(OFS_WDAY, 8'h00);
    u_host.wr(OFS_CTRL2, 8'h02);
    u_host.wr(OFS_MIN_M, 8'h15);
    set_min(7'h15);
    chk({7'h00, irq_oe_q}, 8'h01);
    chk({7'h00, irq_out_q}, 8'h00);
    rchk(OFS_CTRL2, 8'h0a);
    u_host.wr(OFS_CTRL2, 8'h0a);
    rchk(OFS_CTRL2, 8'h0a);
    u_host.wr(OFS_CTRL2, 8'h02);
    repeat (4) @(posedge clock);
    rchk(OFS_CTRL2, 8'h02);
    chk({7'h00, irq_oe_q}, 8'h00);
    set_min(7'h16);
    set_min(7'h15);
    rchk(OFS_CTRL2, 8'h0a);
    u_host.wr(OFS_CTRL2, 8'h08);
    repeat (3) @(posedge clock);
    chk({7'h00, irq_oe_q}, 8'h00);
    u_host.wr(OFS_CTRL2, 8'h00);
    u_host.wr(OFS_HOUR_M, 8'h07);
    set_min(7'h16);
    set_min(7'h15);
    rchk(OFS_CTRL2, 8'h00);
    u_host.wr(OFS_HOUR_M, 8'h87);
    repeat (3) @(posedge clock);
    rchk(OFS_CTRL2, 8'h08);
    rchk(OFS_MIN_M, 8'h15);
    rchk(OFS_HOUR_M, 8'h87);
    u_host.wr(OFS_DAY_M, 8'h31);
    rchk(OFS_DAY_M, 8'h31);
    u_host.wr(OFS_WDAY_M, 8'h86);
    rchk(OFS_WDAY_M, 8'h86);
    stop_test();
  end
endmodule // test_rtcdm_calendar
